// file: sla_pkg.sv
package sla_pkg;

    // Input counts of the three handler instances.
    localparam int SLA_L2_INPUTS    = 16;
    localparam int SLA_L20_INPUTS   = 16;
    localparam int SLA_L21_INPUTS   = 64;
    localparam int SLA_MAX_INPUTS   = 64;

    // Variant select: one handler or two handlers.
    typedef enum logic [0:0]
    {
        SLA_SINGLE = 1'h0,
        SLA_DUAL   = 1'h1
    } sla_variant_type;

    // Sensitivity encoding of one configuration bit.
    localparam logic SLA_SENSE_LEVEL = 1'h0;
    localparam logic SLA_SENSE_EDGE  = 1'h1;

    // Reset values: everything masked, level sensitive, nothing pending.
    localparam logic [SLA_MAX_INPUTS-1:0] SLA_MASK_RST  = '1;
    localparam logic [SLA_MAX_INPUTS-1:0] SLA_SENSE_RST = '0;
    localparam logic [SLA_MAX_INPUTS-1:0] SLA_PEND_RST  = '0;

    // Field positions of the request groups on the first and second handlers.
    localparam int SLA_SERIAL_LO    = 0;
    localparam int SLA_SERIAL_HI    = 3;
    localparam int SLA_UART_LO      = 4;
    localparam int SLA_UART_HI      = 11;
    localparam int SLA_RSV_SINGLE_LO = 12;
    localparam int SLA_RSV_SINGLE_HI = 15;
    localparam int SLA_TIMER_LO     = 1;
    localparam int SLA_TIMER_HI     = 8;
    localparam int SLA_RSV21_A      = 9;
    localparam int SLA_RSV21_B      = 12;
    localparam int SLA_RSV21_C      = 13;
    localparam int SLA_RSV21_HI_LO  = 16;

    // Mask with a one on each reserved input of a given handler.
    function automatic logic [SLA_MAX_INPUTS-1:0] sla_reserved
    (
        input sla_variant_type variant,
        input logic            second
    );
        logic [SLA_MAX_INPUTS-1:0] r;
        r = '0;
        for (int i = 0; i < SLA_MAX_INPUTS; i++)
        begin
            if (variant == SLA_SINGLE && !second)
                r[i] = (i >= SLA_RSV_SINGLE_LO);
            else if (second)
                r[i] = (i == SLA_RSV21_A) || (i == SLA_RSV21_B) ||
                       (i == SLA_RSV21_C) || (i >= SLA_RSV21_HI_LO);
            else
                r[i] = (i >= SLA_L20_INPUTS);
        end
        return r;
    endfunction

    // Required sensitivity for each input of a given handler.
    function automatic logic [SLA_MAX_INPUTS-1:0] sla_sense_cfg
    (
        input sla_variant_type variant,
        input logic            second
    );
        logic [SLA_MAX_INPUTS-1:0] s;
        s = SLA_SENSE_RST;
        if (variant == SLA_SINGLE && !second)
        begin
            for (int i = SLA_SERIAL_LO; i <= SLA_SERIAL_HI; i++)
                s[i] = SLA_SENSE_EDGE;
        end
        return s;
    endfunction

endpackage

// file: sla_link_if.sv
interface sla_link_if
    import sla_pkg::*;
();
    // Peripheral request lines of each handler.
    logic [SLA_L20_INPUTS-1:0] req_h0;
    logic [SLA_L21_INPUTS-1:0] req_h1;
    // Configuration written by software on the other party's side.
    logic [SLA_L20_INPUTS-1:0] mask_h0;
    logic [SLA_L20_INPUTS-1:0] sense_h0;
    logic [SLA_L21_INPUTS-1:0] mask_h1;
    logic [SLA_L21_INPUTS-1:0] sense_h1;
    // Variant strap.
    sla_variant_type           variant;
    // Combined requests towards the first-level handler.
    logic                      level1_input_three;
    logic                      level1_input_seventeen;

    modport device
    (
        input  req_h0,
        input  req_h1,
        input  mask_h0,
        input  sense_h0,
        input  mask_h1,
        input  sense_h1,
        input  variant,
        output level1_input_three,
        output level1_input_seventeen
    );

    modport host
    (
        output req_h0,
        output req_h1,
        output mask_h0,
        output sense_h0,
        output mask_h1,
        output sense_h1,
        output variant,
        input  level1_input_three,
        input  level1_input_seventeen
    );
endinterface

// file: sla_host.sv
module sla_host
    import sla_pkg::*;
(
    // Clock and reset.
    input  wire logic                      ref_clk,
    input  wire logic                      sys_rst,
    // User side: variant and wanted enables.
    input  wire sla_variant_type           cfg_variant,
    input  wire logic [SLA_L20_INPUTS-1:0] user_enable_h0,
    input  wire logic [SLA_L21_INPUTS-1:0] user_enable_h1,
    // User side: peripheral request sources.
    input  wire logic [SLA_L20_INPUTS-1:0] src_req_h0,
    input  wire logic [SLA_L21_INPUTS-1:0] src_req_h1,
    // User side: combined requests seen at the first level.
    output logic                           seen_input_three,
    output logic                           seen_input_seventeen,
    // Link.
    sla_link_if.host                       link
);

    logic [SLA_L20_INPUTS-1:0] mask_h0_ff;
    logic [SLA_L20_INPUTS-1:0] sense_h0_ff;
    logic [SLA_L21_INPUTS-1:0] mask_h1_ff;
    logic [SLA_L21_INPUTS-1:0] sense_h1_ff;
    logic [SLA_L20_INPUTS-1:0] req_h0_ff;
    logic [SLA_L21_INPUTS-1:0] req_h1_ff;
    sla_variant_type           variant_ff;
    logic                      seen3_ff;
    logic                      seen17_ff;
    logic [SLA_MAX_INPUTS-1:0] sense_full_h0;
    logic [SLA_MAX_INPUTS-1:0] rsv_full_h0;

    // A function result cannot be part-selected, so take it whole first.
    assign sense_full_h0 = sla_sense_cfg(cfg_variant, 1'h0);
    assign rsv_full_h0   = sla_reserved(cfg_variant, 1'h0);

    // Sensitivity is fixed by the variant, so software cannot pick wrong.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            variant_ff  <= SLA_SINGLE;
            sense_h0_ff <= SLA_SENSE_RST[SLA_L20_INPUTS-1:0];
            sense_h1_ff <= SLA_SENSE_RST;
        end
        else
        begin
            variant_ff  <= cfg_variant;
            sense_h0_ff <= sense_full_h0[SLA_L20_INPUTS-1:0];
            sense_h1_ff <= sla_sense_cfg(cfg_variant, 1'h1);
        end
    end

    // Reserved inputs stay masked whatever the user asks.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            mask_h0_ff <= SLA_MASK_RST[SLA_L20_INPUTS-1:0];
            mask_h1_ff <= SLA_MASK_RST;
        end
        else
        begin
            mask_h0_ff <= ~user_enable_h0 |
                          rsv_full_h0[SLA_L20_INPUTS-1:0];
            mask_h1_ff <= ~user_enable_h1 |
                          sla_reserved(cfg_variant, 1'h1);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            req_h0_ff <= '0;
            req_h1_ff <= '0;
            seen3_ff  <= 1'h0;
            seen17_ff <= 1'h0;
        end
        else
        begin
            req_h0_ff <= src_req_h0;
            req_h1_ff <= src_req_h1;
            seen3_ff  <= link.level1_input_three;
            seen17_ff <= link.level1_input_seventeen;
        end
    end

    assign link.req_h0   = req_h0_ff;
    assign link.req_h1   = req_h1_ff;
    assign link.mask_h0  = mask_h0_ff;
    assign link.sense_h0 = sense_h0_ff;
    assign link.mask_h1  = mask_h1_ff;
    assign link.sense_h1 = sense_h1_ff;
    assign link.variant  = variant_ff;

    assign seen_input_three     = seen3_ff;
    assign seen_input_seventeen = seen17_ff;

endmodule

// file: sla_device.sv
module sla_core
    import sla_pkg::*;
#(
    parameter int N = SLA_L20_INPUTS
)
(
    // Clock and reset.
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    // Inputs and configuration.
    input  wire logic [N-1:0] req,
    input  wire logic [N-1:0] mask,
    input  wire logic [N-1:0] sense,
    // Status and combined request.
    output logic      [N-1:0] pending,
    output logic              irq
);

    logic [N-1:0] sync1_ff;
    logic [N-1:0] sync2_ff;
    logic [N-1:0] prev_ff;
    logic [N-1:0] latch_ff;
    logic         irq_ff;

    // Request lines come from other logic, so they are synchronised first.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff  <= '0;
        end
        else
        begin
            sync1_ff <= req;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // Edge latch is cleared once the input is masked or set to level; a new
    // edge in the same cycle wins over the mask clear, but not over the clear to level.
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_in
            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                    latch_ff[g] <= 1'h0;
                else if (sense[g] == SLA_SENSE_EDGE &&
                         sync2_ff[g] && !prev_ff[g])
                    latch_ff[g] <= 1'h1;
                else if (mask[g] || sense[g] == SLA_SENSE_LEVEL)
                    latch_ff[g] <= 1'h0;
            end
            assign pending[g] = (sense[g] == SLA_SENSE_EDGE) ?
                                latch_ff[g] : sync2_ff[g];
        end
    endgenerate

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            irq_ff <= 1'h0;
        else
            irq_ff <= |(pending & ~mask);
    end

    assign irq = irq_ff;

endmodule

// Overview of operation
// - Each handler merges its request inputs into one output.
// - Each input is edge or level sensitive.
// - Single variant drives first-level input three.
// - Dual variant: handler zero drives input three.
// - Dual variant: 64-input handler drives input seventeen.
// - Serial inputs 0-3: edge single, level dual.
// - Inputs 4-11 of first handler are level.
// - Second handler timer inputs 1-8 are level.
module sla_device
    import sla_pkg::*;
(
    // Clock and reset.
    input  wire logic                      ref_clk,
    input  wire logic                      sys_rst,
    // User side: pending status of each handler.
    output logic [SLA_L20_INPUTS-1:0]      pending_h0,
    output logic [SLA_L21_INPUTS-1:0]      pending_h1,
    // Link.
    sla_link_if.device                     link
);

    logic irq_h0;
    logic irq_h1;
    logic dual_ff;

    // The second handler reaches input seventeen only in the dual variant.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            dual_ff <= 1'h0;
        else
            dual_ff <= (link.variant == SLA_DUAL);
    end

    sla_core #(.N(SLA_L20_INPUTS)) u_h0
    (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .req     (link.req_h0),
        .mask    (link.mask_h0),
        .sense   (link.sense_h0),
        .pending (pending_h0),
        .irq     (irq_h0)
    );

    sla_core #(.N(SLA_L21_INPUTS)) u_h1
    (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .req     (link.req_h1),
        .mask    (link.mask_h1),
        .sense   (link.sense_h1),
        .pending (pending_h1),
        .irq     (irq_h1)
    );

    // Handler zero feeds input three in both variants.
    assign link.level1_input_three     = irq_h0;
    assign link.level1_input_seventeen = irq_h1 & dual_ff;

endmodule

// file: sla_agg_chk.sv
module sla_agg_chk
    import sla_pkg::*;
(
    // Clock and reset.
    input wire logic                      ref_clk,
    input wire logic                      sys_rst,
    // Link signals.
    input wire logic [SLA_L20_INPUTS-1:0] req_h0,
    input wire logic [SLA_L21_INPUTS-1:0] req_h1,
    input wire logic [SLA_L20_INPUTS-1:0] mask_h0,
    input wire logic [SLA_L20_INPUTS-1:0] sense_h0,
    input wire logic [SLA_L21_INPUTS-1:0] mask_h1,
    input wire logic [SLA_L21_INPUTS-1:0] sense_h1,
    input wire sla_variant_type           variant,
    input wire logic                      level1_input_three,
    input wire logic                      level1_input_seventeen
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking dcb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    mask_three_a: assert property (
        (mask_h0 == '1)[*3] |-> !level1_input_three)
        else $error("masked first handler still requests");
    lvl_three_a: assert property (
        ($stable(req_h0) && $stable(mask_h0) && $stable(sense_h0) &&
        |(req_h0 & ~mask_h0 & ~sense_h0))[*5] |-> level1_input_three)
        else $error("level request missing on input three");
    edge_latch_a: assert property (
        (sense_h0[0] == SLA_SENSE_EDGE && !mask_h0[0] && $rose(req_h0[0]))
        ##1 (sense_h0[0] == SLA_SENSE_EDGE && !mask_h0[0])[*5]
        |-> level1_input_three)
        else $error("edge request not latched");
    single_sev_a: assert property (
        (variant == SLA_SINGLE)[*5] |-> !level1_input_seventeen)
        else $error("input seventeen active in single variant");
    lvl_sev_a: assert property (
        (variant == SLA_DUAL && $stable(req_h1) && $stable(mask_h1) &&
        $stable(sense_h1) && |(req_h1 & ~mask_h1 & ~sense_h1))[*5]
        |-> level1_input_seventeen)
        else $error("level request missing on input seventeen");
    mask_sev_a: assert property (
        (mask_h1 == '1)[*3] |-> !level1_input_seventeen)
        else $error("masked second handler still requests");
    cause_three_a: assert property (
        $rose(level1_input_three) |->
        $past(req_h0, 3) != '0 || $past(req_h0, 4) != '0)
        else $error("input three rose without a request");
    cause_sev_a: assert property (
        $rose(level1_input_seventeen) |->
        $past(req_h1, 3) != '0 || $past(req_h1, 4) != '0)
        else $error("input seventeen rose without a request");
endmodule

// file: tb_second_level_irq_aggregator.sv
module tb_second_level_irq_aggregator;
    timeunit 1ns;
    timeprecision 1ps;
    import sla_pkg::*;

    logic            ref_clk = 1'h0;
    logic            sys_rst = 1'h1;
    sla_variant_type var_s = SLA_SINGLE;
    logic [15:0]     en0 = '0;
    logic [15:0]     rq0 = '0;
    logic [63:0]     en1 = '0;
    logic [63:0]     rq1 = '0;
    logic            three;
    logic            sev;
    logic [15:0]     pend0;
    logic [63:0]     pend1;
    logic [31:0]     seed = 32'h0000001d;
    logic [127:0]    rnd;
    int              num_errors = 0;
    int              samples_checked = 0;

    always #2.5 ref_clk = ~ref_clk;

    sla_link_if sla_link_if_i ();
    sla_host sla_host_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .cfg_variant(var_s), .user_enable_h0(en0), .user_enable_h1(en1),
        .src_req_h0(rq0), .src_req_h1(rq1), .seen_input_three(three),
        .seen_input_seventeen(sev), .link(sla_link_if_i));
    sla_device sla_device_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .pending_h0(pend0), .pending_h1(pend1), .link(sla_link_if_i));
    sla_agg_chk sla_agg_chk_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .req_h0(sla_link_if_i.req_h0), .req_h1(sla_link_if_i.req_h1),
        .mask_h0(sla_link_if_i.mask_h0), .sense_h0(sla_link_if_i.sense_h0),
        .mask_h1(sla_link_if_i.mask_h1), .sense_h1(sla_link_if_i.sense_h1),
        .variant(sla_link_if_i.variant),
        .level1_input_three(sla_link_if_i.level1_input_three),
        .level1_input_seventeen(sla_link_if_i.level1_input_seventeen));

    function automatic logic [63:0] rsv(sla_variant_type v, logic h);
        if (!h)
            return (v == SLA_SINGLE) ? 64'h000000000000f000 : 64'h0;
        return 64'hffffffffffff3200;
    endfunction

    function automatic logic [31:0] nxt(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(logic [63:0] seen, logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", samples_checked,
                 num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Eight cycles cover the path of up to six edges from source to seen output.
    task automatic step(int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic trial(sla_variant_type v, logic [15:0] e0, r0,
                         logic [63:0] e1, r1);
        logic [63:0] f0;
        logic [63:0] f1;
        logic [63:0] edg;
        f0 = {48'h0, e0} & ~rsv(v, 1'h0);
        f1 = (v == SLA_DUAL) ? e1 & ~rsv(v, 1'h1) : 64'h0;
        edg = (v == SLA_SINGLE) ? 64'h000000000000000f : 64'h0;
        var_s = v;
        en0 = e0;
        en1 = e1;
        rq0 = '0;
        rq1 = '0;
        step(8);
        rq0 = r0;
        rq1 = r1;
        step(8);
        chk(three, |(r0 & f0));
        chk(sev, |(r1 & f1));
        chk(pend0 & f0, r0 & f0);
        chk(pend1 & f1, r1 & f1);
        rq0 = '0;
        rq1 = '0;
        step(8);
        chk(three, |(r0 & f0 & edg));
        chk(pend0 & f0, r0 & f0 & edg);
        chk(sev, 1'h0);
        en0 = '0;
        en1 = '0;
        step(8);
        chk(three, 1'h0);
        $display("test done: variant %0d", v);
    endtask

    initial
    begin
        step(16);
        sys_rst = 1'h0;
        step(1);
        trial(SLA_SINGLE, 16'hffff, 16'hf000, '1, '1);
        trial(SLA_SINGLE, 16'hffff, 16'h0001, '0, '0);
        trial(SLA_DUAL, 16'hffff, 16'h000f, '1, 64'hffffffffffff3200);
        trial(SLA_DUAL, 16'h0000, 16'hffff, 64'h1fe, 64'h100);
        for (int i = 0; i < 24; i++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                repeat (7) seed = nxt(seed);
                rnd = {rnd[95:0], seed};
            end
            trial(sla_variant_type'(rnd[0]), rnd[15:0], rnd[31:16],
                  rnd[63:0], rnd[127:64]);
        end
        report_and_stop();
    end

    // A hung run is cut short and counted as a failure.
    initial
    begin
        repeat (50000) @(posedge ref_clk);
        num_errors++;
        report_and_stop();
    end
endmodule
